// ---- rtl/receiver_strobes_pkg.sv ----
// Overview of operation
// - error output is low normally and high while the receiver is in error.
// - four mark inputs, leading edge, active low at reset, polarity programmable; pulses over 150 ns trigger.
// - four active-low programmable frequency outputs, zero up to the top rate.
// - command ready is high only while the receiver accepts host commands.
// - command ready stays low during booting and system reset, and from the second clock of an external reset.
// - a recoverable error leaves command ready asserted.
// - position valid drops at the moment the error flag rises.
// - a fatal error restart holds ready, error and position valid low.
// - position valid is high only while a valid solution is available.
package receiver_strobes_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int MARK_MIN_NS   = 150;
   localparam int MARK_MIN_CYC  =
      (MARK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int NUM_MARKS = 4;
   localparam int NUM_FREQ  = 4;
   localparam int FREQ_W    = 24;
   localparam int MCNT_W    = 5;
   localparam logic [MCNT_W-1:0] MARK_MIN = MCNT_W'(MARK_MIN_CYC);
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MARK_POL  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MARK_FLAG = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TIME      = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MARK_TIME = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_FREQ_DIV  = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_BANK_END  = 8'h40;
   // control and status bit positions
   localparam int CTRL_READY = 0;
   localparam int CTRL_ERROR = 1;
   localparam int CTRL_POS   = 2;
   localparam int CTRL_FATAL = 3;
   localparam int STAT_RESTART = 3;
   localparam logic [NUM_MARKS-1:0] MARK_POL_RESET = 4'h0;
   localparam logic [DATA_W-1:0]    ZERO_WORD      = 32'h0000_0000;
   typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_RESTART} run_state_t;
endpackage

// ---- rtl/receiver_status_strobes.sv ----
`timescale 1ns/100ps
`default_nettype none
module receiver_status_strobes #(
   parameter int RESTART_CYCLES = 1000
) (
   input  wire logic                                       i_clk,
   input  wire logic                                       i_sys_rst,
   input  wire logic                                       i_external_reset_n,
   input  wire logic [receiver_strobes_pkg::NUM_MARKS-1:0] i_mark_input,
   input  wire logic [receiver_strobes_pkg::ADDR_W-1:0]    i_address,
   input  wire logic                                       i_read,
   input  wire logic                                       i_write,
   input  wire logic [receiver_strobes_pkg::DATA_W-1:0]    i_writedata,
   input  wire logic [3:0]                                 i_byteenable,
   output logic [receiver_strobes_pkg::DATA_W-1:0]         o_readdata,
   output logic                                            o_waitrequest,
   output logic                                            o_error,
   output logic                                            o_command_ready,
   output logic                                            o_pos_valid,
   output logic [receiver_strobes_pkg::NUM_FREQ-1:0]       o_freq_output,
   output logic [receiver_strobes_pkg::NUM_MARKS-1:0]      o_mark_trigger
);
   import receiver_strobes_pkg::*;

   localparam int RC_W = $clog2(RESTART_CYCLES + 1);
   localparam logic [RC_W-1:0] RESTART_LAST = RC_W'(RESTART_CYCLES - 1);

   run_state_t                       state_reg, state_next;
   logic [RC_W-1:0]                  rcnt_reg, rcnt_next;
   logic                             ready_req_reg, ready_req_next;
   logic                             err_req_reg, err_req_next;
   logic                             pos_req_reg, pos_req_next;
   logic [NUM_MARKS-1:0]             pol_reg, pol_next;
   logic [NUM_MARKS-1:0]             flag_reg, flag_next;
   logic [NUM_FREQ-1:0][FREQ_W-1:0]  div_reg, div_next;
   logic [DATA_W-1:0]                time_reg, time_next;
   logic                             wait_reg, wait_next;
   logic [DATA_W-1:0]                rdata_reg, rdata_next;
   logic                             err_out_next, rdy_out_next, pos_out_next;
   logic                             wr_go, rd_go;
   logic [NUM_MARKS-1:0]             mark_act, trig_w;
   logic [NUM_MARKS-1:0][DATA_W-1:0] mark_time_w;
   logic [NUM_FREQ-1:0]              fout_w;

   // merge write data into an old word by byte enable
   function automatic logic [DATA_W-1:0] merge_be(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [3:0]        be);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction

   // bus qualifiers: one wait state, then the access completes
   assign wr_go = i_write & ~wait_reg;
   assign rd_go = i_read & wait_reg;

   // free running time base for mark time tags
   always_comb begin
      time_next = time_reg + 32'h0000_0001;
   end
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         time_reg <= ZERO_WORD;
      end else begin
         time_reg <= time_next;
      end
   end

   // per mark: synchroniser, polarity, width qualifier, time capture
   for (genvar m = 0; m < NUM_MARKS; m++) begin : g_mark
      logic              s1_reg, s2_reg, s1_next, s2_next;
      logic [MCNT_W-1:0] cnt_reg, cnt_next;
      logic [DATA_W-1:0] edge_reg, edge_next, tag_reg, tag_next;
      logic              trig_reg, trig_next;
      logic              act;
      assign act = ~(s2_reg ^ pol_reg[m]);
      always_comb begin
         s1_next   = i_mark_input[m];
         s2_next   = s1_reg;
         cnt_next  = ZERO_WORD[MCNT_W-1:0];
         edge_next = edge_reg;
         tag_next  = tag_reg;
         trig_next = 1'b0;
         if (act) begin
            // leading edge stamps, one trigger once width is met
            cnt_next = (cnt_reg == MARK_MIN) ? cnt_reg : cnt_reg + 1'b1;
            if (cnt_reg == ZERO_WORD[MCNT_W-1:0]) begin
               edge_next = time_reg;
            end
            if (cnt_reg == MARK_MIN - 1'b1) begin
               trig_next = 1'b1;
               tag_next  = edge_reg;
            end
         end
      end
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            s1_reg   <= 1'b1;
            s2_reg   <= 1'b1;
            cnt_reg  <= '0;
            edge_reg <= ZERO_WORD;
            tag_reg  <= ZERO_WORD;
            trig_reg <= 1'b0;
         end else begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            cnt_reg  <= cnt_next;
            edge_reg <= edge_next;
            tag_reg  <= tag_next;
            trig_reg <= trig_next;
         end
      end
      assign mark_act[m]    = act;
      assign trig_w[m]      = trig_next;
      assign mark_time_w[m] = tag_reg;
      assign o_mark_trigger[m] = trig_reg;
   end

   // per output: half period divider, zero divisor means 0 Hz idle high
   for (genvar f = 0; f < NUM_FREQ; f++) begin : g_freq
      logic [FREQ_W-1:0] cnt_reg, cnt_next;
      logic              out_reg, out_next;
      always_comb begin
         cnt_next = cnt_reg + 1'b1;
         out_next = out_reg;
         if (state_reg == ST_RESTART || div_reg[f] == '0) begin
            cnt_next = '0;
            out_next = 1'b1;
         end else if (cnt_reg >= div_reg[f] - 1'b1) begin
            cnt_next = '0;
            out_next = ~out_reg;
         end
      end
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            cnt_reg <= '0;
            out_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
         end
      end
      assign fout_w[f] = out_reg;
   end
   assign o_freq_output = fout_w;

   // core: run state, registers, bus answer and status outputs
   always_comb begin
      logic [DATA_W-1:0] wd;
      logic [DATA_W-1:0] dw;
      wd             = merge_be(ZERO_WORD, i_writedata, i_byteenable);
      dw             = ZERO_WORD;
      state_next     = state_reg;
      rcnt_next      = rcnt_reg;
      ready_req_next = ready_req_reg;
      err_req_next   = err_req_reg;
      pos_req_next   = pos_req_reg;
      pol_next       = pol_reg;
      div_next       = div_reg;
      flag_next      = flag_reg;
      wait_next      = ~((i_read | i_write) & wait_reg);
      rdata_next     = rdata_reg;
      if (wr_go) begin
         if (i_address == OFS_CTRL) begin
            ready_req_next = wd[CTRL_READY];
            err_req_next   = wd[CTRL_ERROR];
            pos_req_next   = wd[CTRL_POS];
            if (wd[CTRL_FATAL]) begin
               state_next = ST_RESTART;
               rcnt_next  = '0;
            end
         end else if (i_address == OFS_MARK_POL) begin
            pol_next = wd[NUM_MARKS-1:0];
         end else if (i_address == OFS_MARK_FLAG) begin
            flag_next = flag_reg & ~wd[NUM_MARKS-1:0];
         end else if (i_address >= OFS_FREQ_DIV &&
                      i_address < OFS_BANK_END) begin
            // merge into the 24-bit divisor, upper byte dropped
            dw = merge_be({8'h00, div_reg[i_address[3:2]]}, i_writedata,
                          i_byteenable);
            div_next[i_address[3:2]] = dw[FREQ_W-1:0];
         end
      end
      flag_next = flag_next | trig_w; // set wins over clear
      if (state_reg == ST_RESTART) begin
         ready_req_next = 1'b0;
         err_req_next   = 1'b0;
         pos_req_next   = 1'b0;
         rcnt_next      = rcnt_reg + 1'b1;
         if (rcnt_reg == RESTART_LAST) begin
            state_next = ST_BOOT;
         end
      end else if (state_reg == ST_BOOT && ready_req_reg) begin
         state_next = ST_RUN;
      end
      if (!i_external_reset_n) begin
         state_next     = ST_BOOT;
         ready_req_next = 1'b0;
         err_req_next   = 1'b0;
         pos_req_next   = 1'b0;
      end
      rdy_out_next = (state_reg == ST_RUN);
      err_out_next = (state_reg == ST_RUN) & err_req_reg;
      pos_out_next = (state_reg == ST_RUN) & pos_req_reg &
                     ~err_req_reg;
      if (rd_go) begin
         rdata_next = ZERO_WORD;
         if (i_address == OFS_CTRL) begin
            rdata_next[CTRL_READY] = ready_req_reg;
            rdata_next[CTRL_ERROR] = err_req_reg;
            rdata_next[CTRL_POS]   = pos_req_reg;
         end else if (i_address == OFS_MARK_POL) begin
            rdata_next[NUM_MARKS-1:0] = pol_reg;
         end else if (i_address == OFS_MARK_FLAG) begin
            rdata_next[NUM_MARKS-1:0] = flag_reg;
         end else if (i_address == OFS_STATUS) begin
            rdata_next[CTRL_READY]   = o_command_ready;
            rdata_next[CTRL_ERROR]   = o_error;
            rdata_next[CTRL_POS]     = o_pos_valid;
            rdata_next[STAT_RESTART] = (state_reg == ST_RESTART);
         end else if (i_address == OFS_TIME) begin
            rdata_next = time_reg;
         end else if (i_address >= OFS_MARK_TIME &&
                      i_address < OFS_FREQ_DIV) begin
            rdata_next = mark_time_w[i_address[3:2]];
         end else if (i_address >= OFS_FREQ_DIV &&
                      i_address < OFS_BANK_END) begin
            rdata_next[FREQ_W-1:0] = div_reg[i_address[3:2]];
         end
      end
   end
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg       <= ST_BOOT;
         rcnt_reg        <= '0;
         ready_req_reg   <= 1'b0;
         err_req_reg     <= 1'b0;
         pos_req_reg     <= 1'b0;
         pol_reg         <= MARK_POL_RESET;
         flag_reg        <= '0;
         div_reg         <= '0;
         wait_reg        <= 1'b1;
         rdata_reg       <= ZERO_WORD;
         o_command_ready <= 1'b0;
         o_error         <= 1'b0;
         o_pos_valid     <= 1'b0;
      end else begin
         state_reg       <= state_next;
         rcnt_reg        <= rcnt_next;
         ready_req_reg   <= ready_req_next;
         err_req_reg     <= err_req_next;
         pos_req_reg     <= pos_req_next;
         pol_reg         <= pol_next;
         flag_reg        <= flag_next;
         div_reg         <= div_next;
         wait_reg        <= wait_next;
         rdata_reg       <= rdata_next;
         o_command_ready <= rdy_out_next;
         o_error         <= err_out_next;
         o_pos_valid     <= pos_out_next;
      end
   end
   assign o_waitrequest = wait_reg;
   assign o_readdata    = rdata_reg;

   // checks on the status strobes and marks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_err_follows;
      (state_reg == ST_RUN && err_req_reg) |=> o_error;
   endproperty
   a_err_follows: assert property (p_err_follows)
      else $error("error flag not raised in error state");
   property p_rdy_only_run;
      o_command_ready |-> $past(state_reg == ST_RUN);
   endproperty
   a_rdy_only_run: assert property (p_rdy_only_run)
      else $error("command ready outside run state");
   property p_rdy_ext_reset;
      !i_external_reset_n |-> ##2 !o_command_ready;
   endproperty
   a_rdy_ext_reset: assert property (p_rdy_ext_reset)
      else $error("command ready during external reset");
   property p_err_keeps_rdy;
      o_error |-> o_command_ready;
   endproperty
   a_err_keeps_rdy: assert property (p_err_keeps_rdy)
      else $error("recoverable error dropped command ready");
   property p_err_kills_pos;
      $rose(o_error) |-> !o_pos_valid;
   endproperty
   a_err_kills_pos: assert property (p_err_kills_pos)
      else $error("position valid high with error");
   property p_restart_quiet;
      (state_reg == ST_RESTART) |=>
         !o_error && !o_command_ready && !o_pos_valid;
   endproperty
   a_restart_quiet: assert property (p_restart_quiet)
      else $error("status strobe high during restart");
   property p_pos_needs_req;
      o_pos_valid |-> $past(pos_req_reg) && $past(state_reg == ST_RUN);
   endproperty
   a_pos_needs_req: assert property (p_pos_needs_req)
      else $error("position valid without a solution");
   property p_mark_width;
      o_mark_trigger[0] |-> $past(mark_act[0], 1) && $past(mark_act[0], 8);
   endproperty
   a_mark_width: assert property (p_mark_width)
      else $error("mark trigger on a short pulse");
   property p_mark_once;
      o_mark_trigger[0] |=> !o_mark_trigger[0] ##1 flag_reg[0];
   endproperty
   a_mark_once: assert property (p_mark_once)
      else $error("mark trigger repeated or flag not set");
   property p_freq_idle;
      (div_reg[0] == '0) |=> o_freq_output[0];
   endproperty
   a_freq_idle: assert property (p_freq_idle)
      else $error("disabled frequency output not idle high");
endmodule
`default_nettype wire

// ---- dv/mark_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mark_host_model (
   input  wire logic       i_clk,
   input  wire logic [3:0] i_pol,
   output logic      [3:0] o_mark_input = 4'hf,
   output logic            o_external_reset_n = 1'b1
);
   logic [3:0] act_reg = 4'h0;
   // lines idle at the inactive level of the chosen polarity
   always @(posedge i_clk) begin
      o_mark_input <= ~i_pol ^ act_reg;
   end
   // active pulse of a given number of host clock cycles
   task automatic pulse(input int idx, input int cyc);
      @(posedge i_clk);
      act_reg[idx] <= 1'b1;
      repeat (cyc) @(posedge i_clk);
      act_reg[idx] <= 1'b0;
   endtask
   // card reset held low well past the minimum width
   task automatic card_reset();
      @(posedge i_clk);
      o_external_reset_n <= 1'b0;
      repeat (1001) @(posedge i_clk);
      o_external_reset_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- dv/receiver_status_strobes_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module receiver_status_strobes_bench;
   import receiver_strobes_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_external_reset_n;
   logic [3:0]  i_mark_input;
   logic [7:0]  i_address = 8'h00;
   logic        i_read = 1'b0;
   logic        i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0000_0000;
   logic [31:0] o_readdata;
   logic        o_waitrequest;
   logic        o_error;
   logic        o_command_ready;
   logic        o_pos_valid;
   logic [3:0]  o_freq_output;
   logic [3:0]  o_mark_trigger;
   logic [3:0]  pol = 4'h0;
   logic [31:0] rd;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          trig_cnt [4] = '{0, 0, 0, 0};
   receiver_status_strobes #(.RESTART_CYCLES(4)) dut_u (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_external_reset_n(i_external_reset_n), .i_mark_input(i_mark_input),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(4'hf),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .o_error(o_error), .o_command_ready(o_command_ready),
      .o_pos_valid(o_pos_valid), .o_freq_output(o_freq_output),
      .o_mark_trigger(o_mark_trigger));
   mark_host_model host_u (
      .i_clk(i_clk), .i_pol(pol), .o_mark_input(i_mark_input),
      .o_external_reset_n(i_external_reset_n));
   // 50 MHz clock
   initial forever #10 i_clk = ~i_clk;
   // trigger pulse counters and hang guard
   always @(posedge i_clk) begin
      for (int n = 0; n < 4; n++) begin
         trig_cnt[n] += int'(o_mark_trigger[n] === 1'b1);
      end
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= d;
      i_read <= !wr;
      i_write <= wr;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 50);
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      check(o_waitrequest, 0, "bus answer");
   endtask
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge i_clk);
   endtask
   task automatic t_reset_values();
      check({o_command_ready, o_error, o_pos_valid}, 0, "status idle");
      check(o_freq_output, 4'hf, "freq idle high");
      bus(0, OFS_MARK_POL, 0, rd);
      check(rd, 0, "mark polarity default");
   endtask
   task automatic t_status();
      bus(1, OFS_CTRL, 32'h0000_0005, rd);
      wait_cyc(3);
      check({o_command_ready, o_error, o_pos_valid}, 3'b101, "ready pos");
      bus(0, OFS_STATUS, 0, rd);
      check(rd, 32'h0000_0005, "status ready pos");
      bus(1, OFS_CTRL, 32'h0000_0007, rd);
      wait_cyc(3);
      check({o_command_ready, o_error, o_pos_valid}, 3'b110, "error");
      check(o_pos_valid, 0, "pos drops with error");
      bus(1, OFS_CTRL, 32'h0000_0001, rd);
      wait_cyc(3);
      check(o_error, 0, "error cleared");
      check(o_pos_valid, 0, "no solution");
   endtask
   task automatic t_fatal();
      bus(1, OFS_CTRL, 32'h0000_000F, rd);
      bus(0, OFS_STATUS, 0, rd);
      check(rd, 32'h0000_0008, "status restarting");
      wait_cyc(2);
      check({o_command_ready, o_error, o_pos_valid}, 0, "restart low");
      wait_cyc(10);
      check(o_command_ready, 0, "boot not ready");
   endtask
   task automatic t_marks();
      int base;
      logic [31:0] t0;
      base = trig_cnt[0];
      bus(0, OFS_TIME, 0, t0);
      host_u.pulse(0, 12);
      wait_cyc(20);
      check(trig_cnt[0] - base, 1, "one trigger");
      bus(0, OFS_MARK_FLAG, 0, rd);
      check(rd[0], 1, "mark flag");
      bus(0, OFS_MARK_TIME, 0, rd);
      check(rd - t0 >= 2 && rd - t0 <= 8, 1, "mark time tag");
      bus(1, OFS_MARK_FLAG, 32'h0000_0001, rd);
      bus(0, OFS_MARK_FLAG, 0, rd);
      check(rd[0], 0, "mark flag cleared");
      host_u.pulse(2, 4);
      wait_cyc(20);
      check(trig_cnt[2], 0, "short pulse ignored");
      pol <= 4'h2;
      bus(1, OFS_MARK_POL, 32'h0000_0002, rd);
      bus(0, OFS_MARK_POL, 0, rd);
      check(rd, 32'h0000_0002, "mark polarity set");
      wait_cyc(30);
      base = trig_cnt[1];
      host_u.pulse(1, 10);
      wait_cyc(20);
      check(trig_cnt[1] - base, 1, "active high mark");
   endtask
   task automatic t_freq();
      int n;
      logic v;
      bus(1, OFS_FREQ_DIV, 32'h0000_0003, rd);
      n = 0;
      v = o_freq_output[0];
      while (o_freq_output[0] === v && n < 40) begin
         @(posedge i_clk);
         n++;
      end
      v = o_freq_output[0];
      n = 0;
      while (o_freq_output[0] === v && n < 40) begin
         @(posedge i_clk);
         n++;
      end
      check(n, 3, "half period");
      check(o_freq_output[3:1], 3'h7, "idle outputs");
      bus(0, OFS_FREQ_DIV, 0, rd);
      check(rd, 32'h0000_0003, "divisor readback");
   endtask
   task automatic t_unmapped_and_card_reset();
      bus(0, 8'h80, 0, rd);
      check(rd, 0, "unmapped read");
      bus(1, OFS_CTRL, 32'h0000_0001, rd);
      wait_cyc(3);
      check(o_command_ready, 1, "ready again");
      host_u.card_reset();
      wait_cyc(3);
      check(o_command_ready, 0, "card reset");
   endtask
   initial begin
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      t_reset_values();
      t_status();
      t_fatal();
      t_marks();
      t_freq();
      t_unmapped_and_card_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
